/* logic/gc_defines.svh */
`ifndef GC_DEFINES_SVH
`define GC_DEFINES_SVH

// ----------------------------------------------------------------
// Host I/O ports
// ----------------------------------------------------------------
`define GC_INDEX_PORT 16'h03ce
`define GC_DATA_PORT 16'h03cf

// ----------------------------------------------------------------
// Register indices behind the data port
// ----------------------------------------------------------------
`define IDX_FILL_COLOUR 4'h0
`define IDX_FILL_ENABLE 4'h1
`define IDX_REF_COLOUR 4'h2
`define IDX_LOGIC_OP 4'h3
`define IDX_READ_PLANE 4'h4
`define IDX_MODE 4'h5
`define IDX_WINDOW 4'h6
`define IDX_IGNORE 4'h7
`define IDX_PIXEL_MASK 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OP_ROT_LSB 0
`define OP_FUNC_LSB 3
`define MODE_WPATH_LSB 0
`define MODE_RDCMP 3
`define MODE_ODD_EVEN 4
`define MODE_SHF_OE 5
`define MODE_SHF_256 6
`define WIN_GFX 0
`define WIN_CHAIN 1
`define WIN_MAP_LSB 2

// ----------------------------------------------------------------
// Reset values (contents are undefined at power-on)
// ----------------------------------------------------------------
`define RST_INDEX 4'h0
`define RST_COLOUR 4'h0
`define RST_LOGIC_OP 5'h00
`define RST_READ_PLANE 2'h0
`define RST_MODE 7'h00
`define RST_PIXEL_MASK 8'hff

// ----------------------------------------------------------------
// Host memory windows
// ----------------------------------------------------------------
`define WIN_BASE_A 20'ha0000
`define WIN_BASE_B 20'hb0000
`define WIN_BASE_C 20'hb8000
`define WIN_SIZE_128K 20'h20000
`define WIN_SIZE_64K 20'h10000
`define WIN_SIZE_32K 20'h08000

`endif

/* logic/gc_pkg.sv */
package gc_pkg;

   typedef enum logic [1:0] {
      WP_FILL_ROP = 2'h0,
      WP_LATCH = 2'h1,
      WP_COLOUR = 2'h2,
      WP_PATTERN = 2'h3
   } write_path_t;

   typedef struct packed {
      logic [3:0] idx;
      logic [3:0] fill_col;
      logic [3:0] fill_en;
      logic [3:0] ref_col;
      logic [4:0] op;
      logic [1:0] rd_plane;
      logic [6:0] mode;
      logic [3:0] win;
      logic [3:0] ignore;
      logic [7:0] bmask;
      logic [31:0] latch;
      logic [15:0] vm_addr;
      logic [3:0] vm_we;
      logic [31:0] vm_wdata;
      logic vm_rd;
      logic rd_a0;
      logic [7:0] mem_rdata;
      logic mem_rvalid;
      logic [7:0] io_rdata;
      logic io_rvalid;
      logic [31:0] pix;
   } gc_state_t;

endpackage

/* logic/gc_datapath.sv */
// Operation
// (RULE1) Index port selects register, data port accesses it
// (RULE2) Index is four bits, upper bits read zero
// (RULE3) Keep per-plane fill colour for modes 0,3
// (RULE4) Mode 0: enabled planes take fill colour
// (RULE5) Read mode 1 returns per-pixel colour match
// (RULE6) Rotate write data right by count
// (RULE7) Logic op pass/AND/OR/XOR, not mode 1
// (RULE8) Read mode 0 plane select, A0 in odd/even
// (RULE9) Write path 0: rotate, fill, op, mask
// (RULE10) Write path 1 copies latches unchanged
// (RULE11) Write path 2 replicates data bits 3-0
// (RULE12) Write path 3: fill colour, rotated-data mask
// (RULE13) Read-compare bit picks plane or match
// (RULE14) Odd/even: even address planes 0,2
// (RULE15) Odd/even shift interleaves plane pairs
// (RULE16) 256-colour shift overrides odd/even shift
// (RULE17) Graphics addressing disables character latches
// (RULE18) Chaining replaces A0, A0 picks planes
// (RULE19) Window code selects host memory range
// (RULE20) Ignore bit 0 drops plane from compare
// (RULE21) Mask zero keeps latch value
// (RULE22) Host read loads the four latches
// (RULE23) Order: rotate, fill, op, mask
// (RULE24) Reserved bits and unused indices read zero
`include "gc_defines.svh"

module gc_datapath (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Host I/O cycles
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   output logic io_rvalid_o,
   // Host memory cycles
   input wire logic [19:0] mem_addr_i,
   input wire logic mem_wr_i,
   input wire logic mem_rd_i,
   input wire logic [7:0] mem_wdata_i,
   output logic mem_hit_o,
   output logic [7:0] mem_rdata_o,
   output logic mem_rvalid_o,
   // Video memory, four planes of eight bits
   output logic [15:0] vm_addr_o,
   output logic [3:0] vm_we_o,
   output logic [31:0] vm_wdata_o,
   output logic vm_rd_o,
   input wire logic [31:0] vm_rdata_i,
   // Display side
   input wire logic disp_load_i,
   input wire logic [31:0] disp_planes_i,
   output logic [31:0] disp_pix_o,
   output logic char_latch_en_o,
   output logic gfx_addressing_o
);

   gc_pkg::gc_state_t s, n;
   gc_pkg::write_path_t wpath;
   logic hit, oe_sel, chain;
   logic [19:0] off;
   logic [15:0] vaddr;
   logic [3:0] wplanes;
   logic [31:0] wdata;
   logic [7:0] rot;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] rotr(input logic [7:0] d,
                                       input logic [2:0] c);
      logic [15:0] t;
      t = {d, d} >> c;
      return t[7:0];
   endfunction

   function automatic logic [7:0] logic_fn(input logic [7:0] a,
                                           input logic [7:0] l,
                                           input logic [1:0] f);
      case (f)
         2'h1: logic_fn = a & l;
         2'h2: logic_fn = a | l;
         2'h3: logic_fn = a ^ l;
         default: logic_fn = a;
      endcase
   endfunction

   function automatic logic [7:0] reg_read(input gc_pkg::gc_state_t r,
                                           input logic [3:0] i);
      case (i)
         `IDX_FILL_COLOUR: reg_read = {4'h0, r.fill_col};
         `IDX_FILL_ENABLE: reg_read = {4'h0, r.fill_en};
         `IDX_REF_COLOUR: reg_read = {4'h0, r.ref_col};
         `IDX_LOGIC_OP: reg_read = {3'h0, r.op};
         `IDX_READ_PLANE: reg_read = {6'h00, r.rd_plane};
         `IDX_MODE: reg_read = {1'b0, r.mode};
         `IDX_WINDOW: reg_read = {4'h0, r.win};
         `IDX_IGNORE: reg_read = {4'h0, r.ignore};
         `IDX_PIXEL_MASK: reg_read = r.bmask;
         default: reg_read = 8'h00; // RULE24
      endcase
   endfunction

   // Pixel k occupies bits 4k+3..4k, pixel 0 shown first
   function automatic logic [31:0] fmt(input logic [31:0] p,
                                       input logic [6:0] m);
      logic [31:0] o;
      logic [7:0] ev, od, b;
      int j;
      o = 32'h0;
      for (int k = 0; k < 8; k++) begin
         j = k % 4;
         ev = (k < 4) ? p[7:0] : p[23:16];
         od = (k < 4) ? p[15:8] : p[31:24];
         b = p[8 * (k / 2) +: 8];
         if (m[`MODE_SHF_256]) begin // RULE16
            o[4 * k +: 4] = (k % 2 == 0) ? b[7:4] : b[3:0];
         end else if (m[`MODE_SHF_OE]) begin // RULE15
            o[4 * k +: 4] = {od[7 - 2 * j], od[6 - 2 * j],
                             ev[7 - 2 * j], ev[6 - 2 * j]};
         end else begin
            o[4 * k +: 4] = {p[31 - k], p[23 - k], p[15 - k], p[7 - k]};
         end
      end
      return o;
   endfunction

   // ----------------------------------------------------------------
   // Window decode and plane addressing
   // ----------------------------------------------------------------
   always_comb begin
      logic [19:0] base, size;
      base = `WIN_BASE_A;
      size = `WIN_SIZE_128K;
      case (s.win[`WIN_MAP_LSB +: 2]) // RULE19
         2'h1: size = `WIN_SIZE_64K;
         2'h2: begin
            base = `WIN_BASE_B;
            size = `WIN_SIZE_32K;
         end
         2'h3: begin
            base = `WIN_BASE_C;
            size = `WIN_SIZE_32K;
         end
         default: size = `WIN_SIZE_128K;
      endcase
      off = mem_addr_i - base;
      hit = (mem_addr_i >= base) && (off < size);
   end

   assign chain = s.win[`WIN_CHAIN];
   assign oe_sel = s.mode[`MODE_ODD_EVEN] | chain;
   // RULE18
   assign vaddr = chain ? {off[15:1], off[16]} : off[15:0];
   // RULE14
   assign wplanes = !oe_sel ? 4'hf : (mem_addr_i[0] ? 4'ha : 4'h5);
   assign wpath = gc_pkg::write_path_t'(s.mode[`MODE_WPATH_LSB +: 2]);
   assign rot = rotr(mem_wdata_i, s.op[`OP_ROT_LSB +: 3]); // RULE6

   // ----------------------------------------------------------------
   // Per-plane write data path
   // ----------------------------------------------------------------
   generate
      for (genvar p = 0; p < 4; p++) begin : g_plane
         logic [7:0] src, alu, msk, lat, wd;
         assign lat = s.latch[8 * p +: 8];
         assign wdata[8 * p +: 8] = wd;
         always_comb begin
            case (wpath)
               gc_pkg::WP_COLOUR: src = {8{mem_wdata_i[p]}}; // RULE11
               gc_pkg::WP_PATTERN: src = {8{s.fill_col[p]}}; // RULE12
               default: src = s.fill_en[p] ? {8{s.fill_col[p]}} : rot; // RULE4
            endcase
            alu = logic_fn(src, lat, s.op[`OP_FUNC_LSB +: 2]); // RULE7
            msk = (wpath == gc_pkg::WP_PATTERN) ? (rot & s.bmask) // RULE12
                                                : s.bmask;
            if (wpath == gc_pkg::WP_LATCH) begin
               wd = lat; // RULE10
            end else begin
               wd = (alu & msk) | (lat & ~msk); // RULE21 RULE23
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] cmp, pl;
      logic [1:0] sel;
      n = s;
      n.vm_we = 4'h0;
      n.vm_rd = 1'b0;
      n.mem_rvalid = 1'b0;
      n.io_rvalid = 1'b0;
      cmp = 8'h00;
      pl = 8'h00;
      sel = 2'h0;
      if (io_wr_i && io_addr_i == `GC_INDEX_PORT) begin
         n.idx = io_wdata_i[3:0]; // RULE2
      end
      if (io_wr_i && io_addr_i == `GC_DATA_PORT) begin
         case (s.idx) // RULE1 RULE24
            `IDX_FILL_COLOUR: n.fill_col = io_wdata_i[3:0]; // RULE3
            `IDX_FILL_ENABLE: n.fill_en = io_wdata_i[3:0];
            `IDX_REF_COLOUR: n.ref_col = io_wdata_i[3:0];
            `IDX_LOGIC_OP: n.op = io_wdata_i[4:0];
            `IDX_READ_PLANE: n.rd_plane = io_wdata_i[1:0];
            `IDX_MODE: n.mode = io_wdata_i[6:0] & 7'h7b;
            `IDX_WINDOW: n.win = io_wdata_i[3:0];
            `IDX_IGNORE: n.ignore = io_wdata_i[3:0];
            `IDX_PIXEL_MASK: n.bmask = io_wdata_i;
            default: n.idx = s.idx;
         endcase
      end
      if (io_rd_i && io_addr_i == `GC_INDEX_PORT) begin
         n.io_rdata = {4'h0, s.idx}; // RULE2
         n.io_rvalid = 1'b1;
      end else if (io_rd_i && io_addr_i == `GC_DATA_PORT) begin
         n.io_rdata = reg_read(s, s.idx); // RULE1
         n.io_rvalid = 1'b1;
      end
      if (mem_wr_i && hit) begin
         n.vm_addr = vaddr;
         n.vm_we = wplanes; // RULE9
         n.vm_wdata = wdata;
      end else if (mem_rd_i && hit) begin
         n.vm_addr = vaddr;
         n.vm_rd = 1'b1;
         n.rd_a0 = mem_addr_i[0];
      end
      if (s.vm_rd) begin
         n.latch = vm_rdata_i; // RULE22
         for (int b = 0; b < 8; b++) begin
            cmp[b] = ((s.ref_col ^ {vm_rdata_i[24 + b], vm_rdata_i[16 + b],
                       vm_rdata_i[8 + b], vm_rdata_i[b]}) & s.ignore)
                     == 4'h0; // RULE5 RULE20
         end
         sel = oe_sel ? {s.rd_plane[1], s.rd_a0} : s.rd_plane; // RULE8
         pl = vm_rdata_i[8 * sel +: 8];
         n.mem_rdata = s.mode[`MODE_RDCMP] ? cmp : pl; // RULE13
         n.mem_rvalid = 1'b1;
      end
      if (disp_load_i) begin
         n.pix = fmt(disp_planes_i, s.mode);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
         s.idx <= `RST_INDEX;
         s.fill_col <= `RST_COLOUR;
         s.fill_en <= `RST_COLOUR;
         s.ref_col <= `RST_COLOUR;
         s.ignore <= `RST_COLOUR;
         s.win <= `RST_COLOUR;
         s.op <= `RST_LOGIC_OP;
         s.rd_plane <= `RST_READ_PLANE;
         s.mode <= `RST_MODE;
         s.bmask <= `RST_PIXEL_MASK;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign io_rdata_o = s.io_rdata;
   assign io_rvalid_o = s.io_rvalid;
   assign mem_hit_o = hit;
   assign mem_rdata_o = s.mem_rdata;
   assign mem_rvalid_o = s.mem_rvalid;
   assign vm_addr_o = s.vm_addr;
   assign vm_we_o = s.vm_we;
   assign vm_wdata_o = s.vm_wdata;
   assign vm_rd_o = s.vm_rd;
   assign disp_pix_o = s.pix;
   assign gfx_addressing_o = s.win[`WIN_GFX];
   assign char_latch_en_o = ~s.win[`WIN_GFX]; // RULE17

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_index_readback: assert property ( // RULE2
      io_rd_i && io_addr_i == `GC_INDEX_PORT
      |=> io_rvalid_o && io_rdata_o == {4'h0, $past(s.idx)})
      else $error("index readback wrong");

   chk_data_routing: assert property ( // RULE1
      io_wr_i && io_addr_i == `GC_DATA_PORT && s.idx == `IDX_PIXEL_MASK
      |=> s.bmask == $past(io_wdata_i))
      else $error("data port not routed to mask");

   chk_latch_copy: assert property ( // RULE10
      mem_wr_i && hit && s.mode[1:0] == 2'h1
      |=> vm_wdata_o == $past(s.latch))
      else $error("write path 1 not latch copy");

   chk_mask_keeps: assert property ( // RULE21
      mem_wr_i && hit && s.mode[1:0] == 2'h0 && s.bmask == 8'h00
      |=> vm_wdata_o == $past(s.latch))
      else $error("zero mask changed memory");

   chk_fill_plane0: assert property ( // RULE4
      mem_wr_i && hit && s.mode[1:0] == 2'h0 && s.fill_en[0]
      && s.op[4:3] == 2'h0 && s.bmask == 8'hff
      |=> vm_wdata_o[7:0] == {8{$past(s.fill_col[0])}})
      else $error("fill colour not written");

   chk_read_timing: assert property ( // RULE22
      mem_rd_i && !mem_wr_i && hit |=> vm_rd_o ##1 mem_rvalid_o)
      else $error("read answer late");

   chk_latch_load: assert property ( // RULE22
      vm_rd_o |=> s.latch == $past(vm_rdata_i))
      else $error("latches not loaded");

   chk_even_planes: assert property ( // RULE14
      mem_wr_i && hit && oe_sel && !mem_addr_i[0] |=> vm_we_o == 4'h5)
      else $error("odd/even plane select wrong");

   chk_window_miss: assert property ( // RULE19
      !hit && !s.vm_rd |=> !vm_rd_o && vm_we_o == 4'h0 ##1 !mem_rvalid_o)
      else $error("access outside window");

   chk_compare_dc: assert property ( // RULE20
      mem_rd_i && !mem_wr_i && !io_wr_i && hit && s.mode[`MODE_RDCMP]
      && s.ignore == 4'h0 |=> ##1 mem_rdata_o == 8'hff)
      else $error("don't care planes compared");

   cov_write_path3: cover property (mem_wr_i && hit && s.mode[1:0] == 2'h3);
   cov_compare_read: cover property (mem_rvalid_o && s.mode[`MODE_RDCMP]);
   cov_chain_write: cover property (mem_wr_i && hit && chain);

endmodule

/* tb/vmem_model.sv */
module vmem_model (
   // Clock
   input wire logic clk_i,
   // Plane port
   input wire logic [15:0] vm_addr_i,
   input wire logic [3:0] vm_we_i,
   input wire logic [31:0] vm_wdata_i,
   input wire logic vm_rd_i,
   output logic [31:0] vm_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [256];
   logic [31:0] last_q = 32'h5a5a5a5a;
   // Bus shows junk outside read strobe
   assign vm_rdata_o = vm_rd_i ? mem[vm_addr_i[7:0]] : ~last_q;
   always @(posedge clk_i) begin
      if (vm_rd_i) begin
         last_q <= mem[vm_addr_i[7:0]];
      end
      for (int p = 0; p < 4; p++) begin
         if (vm_we_i[p]) begin
            mem[vm_addr_i[7:0]][8*p +: 8] <= vm_wdata_i[8*p +: 8];
         end
      end
   end
endmodule

/* tb/tb_top.sv */
`include "gc_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] io_addr_i = 16'h0000;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   logic [7:0] io_rdata_o;
   logic io_rvalid_o;
   logic [19:0] mem_addr_i = 20'h00000;
   logic mem_wr_i = 1'b0;
   logic mem_rd_i = 1'b0;
   logic [7:0] mem_wdata_i = 8'h00;
   logic mem_hit_o, mem_rvalid_o, vm_rd_o, disp_load_i = 1'b0;
   logic [7:0] mem_rdata_o;
   logic [15:0] vm_addr_o, va_seen;
   logic [3:0] vm_we_o, we_seen;
   logic [31:0] vm_wdata_o, vm_rdata_i, disp_planes_i = 32'h0, disp_pix_o;
   logic char_latch_en_o, gfx_addressing_o;
   int err_count = 0;
   int total_checks = 0;

   always #2.5 clk_i = ~clk_i;

   gc_datapath dut (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
      .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
      .mem_wdata_i(mem_wdata_i), .mem_hit_o(mem_hit_o),
      .mem_rdata_o(mem_rdata_o), .mem_rvalid_o(mem_rvalid_o),
      .vm_addr_o(vm_addr_o), .vm_we_o(vm_we_o), .vm_wdata_o(vm_wdata_o),
      .vm_rd_o(vm_rd_o), .vm_rdata_i(vm_rdata_i),
      .disp_load_i(disp_load_i), .disp_planes_i(disp_planes_i),
      .disp_pix_o(disp_pix_o), .char_latch_en_o(char_latch_en_o),
      .gfx_addressing_o(gfx_addressing_o));

   vmem_model vm (.clk_i(clk_i), .vm_addr_i(vm_addr_o), .vm_we_i(vm_we_o),
      .vm_wdata_i(vm_wdata_o), .vm_rd_i(vm_rd_o), .vm_rdata_o(vm_rdata_i));

   // ----------------------------------------
   // Bus cycles and compare
   // ----------------------------------------
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %0t %s: %h not %h", $time, msg, got, exp);
      end
   endtask
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      tick();
      io_wr_i = 1'b0;
      tick();
   endtask
   task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
      io_addr_i = a;
      io_rd_i = 1'b1;
      tick();
      io_rd_i = 1'b0;
      d = io_rdata_o;
      chk(io_rvalid_o, 1'b1, "io answer");
      tick();
   endtask
   task automatic reg_wr(input logic [3:0] i, input logic [7:0] v);
      io_wr(`GC_INDEX_PORT, {4'h0, i});
      io_wr(`GC_DATA_PORT, v);
   endtask
   task automatic reg_rd(input logic [3:0] i, output logic [7:0] v);
      io_wr(`GC_INDEX_PORT, {4'h0, i});
      io_rd(`GC_DATA_PORT, v);
   endtask
   task automatic mem_wr(input logic [19:0] a, input logic [7:0] d);
      mem_addr_i = a;
      mem_wdata_i = d;
      mem_wr_i = 1'b1;
      tick();
      mem_wr_i = 1'b0;
      we_seen = vm_we_o;
      va_seen = vm_addr_o;
      tick();
   endtask
   task automatic mem_rd(input logic [19:0] a, output logic [7:0] d);
      mem_addr_i = a;
      mem_rd_i = 1'b1;
      tick();
      mem_rd_i = 1'b0;
      tick();
      chk(mem_rvalid_o, 1'b1, "mem answer");
      d = mem_rdata_o;
   endtask

   // ----------------------------------------
   // Expected plane data and pixel output
   // ----------------------------------------
   function automatic logic [31:0] wexp(input logic [1:0] md,
      input logic [7:0] d, bm, input logic [4:0] op, input logic [31:0] l,
      input logic [3:0] fc, fe);
      logic [7:0] r, v, m, lp;
      r = (d >> op[2:0]) | (d << (8 - op[2:0]));
      for (int p = 0; p < 4; p++) begin
         lp = l[8*p +: 8];
         m = bm;
         v = {8{fc[p]}};
         if (md == 2'h0 && !fe[p])
            v = r;
         if (md == 2'h2)
            v = {8{d[p]}};
         if (md == 2'h3)
            m = r & bm;
         case (op[4:3])
            2'h1: v = v & lp;
            2'h2: v = v | lp;
            2'h3: v = v ^ lp;
            default: ;
         endcase
         v = (v & m) | (lp & ~m);
         wexp[8*p +: 8] = md == 2'h1 ? lp : v;
      end
   endfunction
   function automatic logic [31:0] sexp(input logic [1:0] sm,
      input logic [31:0] w);
      logic [7:0] ev, od;
      int j;
      for (int k = 0; k < 8; k++) begin
         ev = k < 4 ? w[7:0] : w[23:16];
         od = k < 4 ? w[15:8] : w[31:24];
         j = k % 4;
         if (sm[1])
            sexp[4*k +: 4] = w[8*(k/2) + 4*(1-k%2) +: 4];
         else if (sm[0])
            sexp[4*k +: 4] = {od[7-2*j], od[6-2*j], ev[7-2*j], ev[6-2*j]};
         else
            sexp[4*k +: 4] = {w[31-k], w[23-k], w[15-k], w[7-k]};
      end
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_regs();
      logic [7:0] v;
      logic [7:0] msk [10] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b,
         8'h0f, 8'h0f, 8'hff, 8'h00};
      io_rd(`GC_INDEX_PORT, v);
      chk(v, 8'h00, "index rst");
      reg_rd(4'h8, v);
      chk(v, 8'hff, "mask rst");
      for (int i = 0; i < 10; i++) begin
         reg_wr(i[3:0], 8'hff);
         reg_rd(i[3:0], v);
         chk(v, msk[i], "reg rw");
      end
      io_wr(`GC_INDEX_PORT, 8'hf2);
      io_rd(`GC_INDEX_PORT, v);
      chk(v, 8'h02, "index");
      io_addr_i = 16'h03cd;
      io_rd_i = 1'b1;
      tick();
      io_rd_i = 1'b0;
      chk(io_rvalid_o, 1'b0, "stray");
      tick();
      for (int i = 0; i < 9; i++)
         reg_wr(i[3:0], i == 8 ? 8'hff : 8'h00);
   endtask
   task automatic s_write();
      logic [31:0] lat = 32'h3c96a55a;
      logic [7:0] d;
      vm.mem[8'h40] = lat;
      for (int p = 0; p < 4; p++) begin
         reg_wr(4'h4, p[7:0]);
         mem_rd(20'ha0040, d);
         chk(d, lat[8*p +: 8], "plane rd");
      end
      reg_wr(4'h0, 8'h05);
      reg_wr(4'h1, 8'h03);
      reg_wr(4'h8, 8'h3c);
      for (int i = 0; i < 16; i++) begin
         reg_wr(4'h3, {3'h0, i[1:0], i[3:1]});
         reg_wr(4'h5, {6'h0, i[3:2]});
         d = 8'hc5 ^ i[7:0];
         mem_wr(20'ha0050 + i, d);
         chk(we_seen, 4'hf, "we");
         chk(vm.mem[8'h50 + i], wexp(i[3:2], d, 8'h3c, {i[1:0], i[3:1]},
            lat, 4'h5, 4'h3), "wr");
      end
      reg_wr(4'h3, 8'h00);
      reg_wr(4'h5, 8'h00);
      for (int k = 0; k < 2; k++) begin
         reg_wr(4'h8, k ? 8'h00 : 8'hff);
         mem_wr(20'ha0070 + k[19:0], 8'h81);
         chk(vm.mem[8'h70 + k], wexp(2'h0, 8'h81, k ? 8'h00 : 8'hff, 5'h00,
            lat, 4'h5, 4'h3), "full or zero mask");
      end
   endtask
   task automatic s_cmp();
      logic [7:0] d, e;
      logic [3:0] ign [3] = '{4'hf, 4'h5, 4'h0};
      logic [31:0] w = 32'hf0ccaa0f;
      vm.mem[8'h60] = w;
      reg_wr(4'h5, 8'h08);
      reg_wr(4'h2, 8'h0a);
      for (int k = 0; k < 3; k++) begin
         reg_wr(4'h7, {4'h0, ign[k]});
         mem_rd(20'ha0060, d);
         for (int b = 0; b < 8; b++)
            e[b] = (({w[24+b], w[16+b], w[8+b], w[b]} ^ 4'ha) & ign[k]) == 0;
         chk(d, e, "compare");
      end
   endtask
   task automatic s_planes();
      logic [7:0] d;
      reg_wr(4'h5, 8'h10);
      mem_wr(20'ha0071, 8'h55);
      chk(we_seen, 4'ha, "odd we");
      mem_wr(20'ha0070, 8'h55);
      chk(we_seen, 4'h5, "even we");
      vm.mem[8'h71] = 32'h44332211;
      reg_wr(4'h4, 8'h02);
      mem_rd(20'ha0071, d);
      chk(d, 8'h44, "oe rd");
      reg_wr(4'h5, 8'h00);
      reg_wr(4'h6, 8'h02);
      mem_wr(20'hb0004, 8'h00);
      chk(va_seen, 16'h0005, "chain addr");
      chk(we_seen, 4'h5, "chain we");
      reg_wr(4'h6, 8'h00);
   endtask
   task automatic s_window();
      logic [19:0] lo [4] = '{20'ha0000, 20'ha0000, 20'hb0000, 20'hb8000};
      logic [19:0] hi [4] = '{20'hbffff, 20'haffff, 20'hb7fff, 20'hbffff};
      for (int c = 0; c < 4; c++) begin
         reg_wr(4'h6, {4'h0, c[1:0], 2'h1});
         chk({char_latch_en_o, gfx_addressing_o}, 2'h1, "gfx");
         mem_addr_i = lo[c] - 20'h1;
         tick();
         chk(mem_hit_o, 1'b0, "below");
         mem_addr_i = lo[c];
         tick();
         chk(mem_hit_o, 1'b1, "base");
         mem_addr_i = hi[c];
         tick();
         chk(mem_hit_o, 1'b1, "top");
         mem_addr_i = hi[c] + 20'h1;
         tick();
         chk(mem_hit_o, 1'b0, "above");
      end
      reg_wr(4'h6, 8'h00);
      chk({char_latch_en_o, gfx_addressing_o}, 2'h2, "text");
   endtask
   task automatic s_shift();
      logic [7:0] m [3] = '{8'h00, 8'h20, 8'h60};
      for (int i = 0; i < 3; i++) begin
         reg_wr(4'h5, m[i]);
         disp_planes_i = 32'h9ac3_5e71;
         disp_load_i = 1'b1;
         tick();
         disp_load_i = 1'b0;
         chk(disp_pix_o, sexp(m[i][6:5], disp_planes_i), "pix");
         tick();
      end
   endtask

   task automatic conclude();
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      tick();
      s_regs();
      s_write();
      s_cmp();
      s_planes();
      s_window();
      s_shift();
      conclude();
   end
   initial begin
      #200000;
      err_count++;
      conclude();
   end
endmodule
